// >>> tws_twowire.sv
`timescale 1ns/100ps
`include "tws_consts.svh"
module tws_twowire #(
	parameter int FILT_CYC = `TW_FILT_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        sys_rst_in,
	// Special function register port
	input  wire logic [7:0]  sfr_addr_in,
	input  wire logic        sfr_wr_in,
	input  wire logic        sfr_rd_in,
	input  wire logic [7:0]  sfr_wdata_in,
	output logic      [7:0]  sfr_rdata_out,
	// Interrupt enables and request
	input  wire logic        twi_int_enable_in,
	input  wire logic        global_int_enable_in,
	output logic             irq_out,
	output logic      [15:0] irq_vector_out,
	// Serial data pin
	input  wire logic        serial_data_pin_in,
	output logic             serial_data_pin_out,
	output logic             serial_data_pin_oe_out,
	// Serial clock pin
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe_out
);
	import tws_pkg::*;

	tws_state_s s;
	tws_state_s n;
	logic       scl_f;
	logic       sda_f;
	logic       addr_hit;
	logic       hw_set;
	logic       data_acc;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic       gcall;

	// Spike filters on both lines
	tws_glitch_filter #(.FILT_CYC(FILT_CYC)) u_flt_scl (
		.ref_clk_in (ref_clk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     (serial_clock_pin_in),
		.level_out  (scl_f)
	);
	tws_glitch_filter #(.FILT_CYC(FILT_CYC)) u_flt_sda (
		.ref_clk_in (ref_clk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     (serial_data_pin_in),
		.level_out  (sda_f)
	);

	// Address comparison against the four address registers
	tws_addr_match #(.NUM_ADDR(4)) u_match (
		.addr_tab_in ({s.adr3, s.adr2, s.adr1, s.adr0}),
		.rx_addr_in  (s.shreg[7:1]),
		.match_out   (addr_hit)
	);

	// Bus events from the filtered lines
	assign scl_rise = scl_f & ~s.scl_d;
	assign scl_fall = ~scl_f & s.scl_d;
	assign start_ev = scl_f & s.scl_d & s.sda_d & ~sda_f;
	assign stop_ev  = scl_f & s.scl_d & ~s.sda_d & sda_f;
	assign gcall    = (s.shreg[7:1] == `TW_GCALL);
	assign data_acc = (sfr_rd_in | sfr_wr_in) & (sfr_addr_in == `TW_ADR_DATA);

	// Next-state logic for registers, slave engine and pins
	always_comb begin
		n       = s;
		hw_set  = 1'b0;
		n.scl_d = scl_f;
		n.sda_d = sda_f;
		// Software writes
		if (sfr_wr_in) begin
			case (sfr_addr_in)
				`TW_ADR_A0: n.adr0 = sfr_wdata_in;
				`TW_ADR_A1: n.adr1 = sfr_wdata_in;
				`TW_ADR_A2: n.adr2 = sfr_wdata_in;
				`TW_ADR_A3: n.adr3 = sfr_wdata_in;
				`TW_ADR_DATA: n.dbuf = sfr_wdata_in;
				`TW_ADR_CTRL: begin
					n.msel = sfr_wdata_in[`TW_B_MSEL];
					if (sfr_wdata_in[`TW_B_MSEL]) begin
						n.master_out_value = sfr_wdata_in[`TW_B_MDO];
						n.master_out_enable = sfr_wdata_in[`TW_B_MDE];
						n.master_clock_value = sfr_wdata_in[`TW_B_MCO];
					end else begin
						n.stop_ie = sfr_wdata_in[`TW_B_SIE];
						n.irst    = sfr_wdata_in[`TW_B_IRST];
						n.gc      = s.gc & sfr_wdata_in[`TW_B_GC];
						n.flag    = s.flag & sfr_wdata_in[`TW_B_FLAG];
					end
				end
				default: begin
				end
			endcase
		end
		// Data access clears the flag and is counted
		if (data_acc) begin
			n.flag = 1'b0;
			n.acc  = 1'b1;
		end
		// Master data-in sample on clock rise
		if (s.msel && !s.master_out_enable && scl_rise) begin
			n.master_in_sample = sda_f;
		end
		// Hardware slave engine
		case (s.st)
			S_IDLE: begin
			end
			S_ADDR, S_RX: begin
				if (scl_rise) begin
					n.bits = s.bits + 4'h1;
					if (s.bits < `TW_BYTE_BITS) begin
						n.shreg = {s.shreg[6:0], sda_f};
					end
				end
				if (scl_fall && s.bits == `TW_BYTE_BITS) begin
					if (s.st == S_ADDR && !addr_hit && !gcall) begin
						n.st = S_IDLE;
					end else begin
						n.sda_low = 1'b1;
					end
				end
				if (scl_fall && s.bits == `TW_ACK_BIT) begin
					n.sda_low = 1'b0;
					hw_set    = 1'b1;
					n.dbuf    = s.shreg;
					n.st      = S_STRETCH;
					if (s.st == S_ADDR) begin
						n.dir     = s.shreg[0];
						n.matched = 1'b1;
						n.src     = s.rep ? `TW_SRC_REP : `TW_SRC_START;
						if (gcall) begin
							n.gc = 1'b1;
						end
					end else begin
						n.src = `TW_SRC_DATA;
					end
				end
			end
			S_STRETCH: begin
				if (!s.flag) begin
					n.bits = 4'h0;
					if (s.dir) begin
						n.st      = S_TX;
						n.shreg   = s.dbuf;
						n.sda_low = ~s.dbuf[7];
					end else begin
						n.st = S_RX;
					end
				end
			end
			S_TX: begin
				if (scl_rise) begin
					n.bits = s.bits + 4'h1;
					if (s.bits == `TW_BYTE_BITS) begin
						n.ack_ok = ~sda_f;
					end
				end
				if (scl_fall) begin
					if (s.bits < `TW_BYTE_BITS) begin
						n.shreg   = {s.shreg[6:0], 1'b0};
						n.sda_low = ~s.shreg[6]; // Next bit, LSB included
					end else if (s.bits == `TW_BYTE_BITS) begin
						n.sda_low = 1'b0;
					end else if (s.ack_ok) begin
						hw_set = 1'b1;
						n.src  = `TW_SRC_DATA;
						n.st   = S_STRETCH;
					end else begin
						n.st      = S_IDLE;
						n.matched = 1'b0;
					end
				end
			end
			S_HALT: begin
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase
		// Start and stop conditions
		if (!s.msel && s.st != S_HALT) begin
			if (stop_ev && s.st != S_IDLE) begin
				n.st      = S_IDLE;
				n.sda_low = 1'b0;
				n.matched = 1'b0;
				if (s.matched && s.stop_ie) begin
					hw_set = 1'b1;
					n.src  = `TW_SRC_STOP;
				end
			end else if (start_ev && (s.st == S_IDLE || !s.dir)) begin
				n.st      = S_ADDR;
				n.bits    = 4'h0;
				n.rep     = (s.st != S_IDLE);
				n.sda_low = 1'b0;
				n.matched = 1'b0;
			end
		end
		// Hardware set wins over any clear in the same cycle except the interface reset clear
		if (hw_set) begin
			n.flag = 1'b1;
			n.acc  = 1'b0;
		end
		// A repeat data access per interrupt halts the slave, over any engine move that does not set the flag
		if (data_acc && s.acc && !s.msel && !hw_set) begin
			n.st = S_HALT;
		end
		// Interface reset or master mode keeps the slave idle
		if (s.irst || s.msel) begin
			n.st      = S_IDLE;
			n.sda_low = 1'b0;
			n.bits    = 4'h0;
			n.matched = 1'b0;
			if (s.irst) begin
				n.flag = 1'b0;
				n.acc  = 1'b0;
			end
		end
		// Pin drivers; the clock stays low until a new transmit bit has settled
		n.sda_o  = s.msel ? s.master_out_value : 1'b0;
		n.sda_oe = s.msel ? s.master_out_enable : s.sda_low;
		n.scl_o  = s.msel ? s.master_clock_value : 1'b0;
		n.scl_oe = s.msel | (s.st == S_STRETCH) | (s.st == S_TX && s.sda_oe != s.sda_low);
		n.irq    = s.flag & twi_int_enable_in & global_int_enable_in;
		// Read data, held between reads
		if (sfr_rd_in) begin
			case (sfr_addr_in)
				`TW_ADR_A0: n.rdata = s.adr0;
				`TW_ADR_A1: n.rdata = s.adr1;
				`TW_ADR_A2: n.rdata = s.adr2;
				`TW_ADR_A3: n.rdata = s.adr3;
				`TW_ADR_DATA: n.rdata = s.dbuf;
				`TW_ADR_CTRL: begin
					if (s.msel) begin
						n.rdata = {s.master_out_value, s.master_out_enable, s.master_clock_value, s.master_in_sample, 1'b1, 3'h0};
					end else begin
						n.rdata = {s.stop_ie, s.gc, s.src, 1'b0, s.irst, s.dir, s.flag};
					end
				end
				default: n.rdata = 8'h00;
			endcase
		end
	end

	// State register; slave mode after reset
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			s <= '{st: S_IDLE, adr0: `TW_RST_A0, adr1: `TW_RST_AX, adr2: `TW_RST_AX,
				adr3: `TW_RST_AX, dbuf: `TW_RST_DATA, scl_d: 1'b1, sda_d: 1'b1, vec: `TW_VECTOR, default: '0};
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign sfr_rdata_out           = s.rdata;
	assign irq_out                 = s.irq;
	assign irq_vector_out          = s.vec;
	assign serial_data_pin_out     = s.sda_o;
	assign serial_data_pin_oe_out  = s.sda_oe;
	assign serial_clock_pin_out    = s.scl_o;
	assign serial_clock_pin_oe_out = s.scl_oe;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// Interface reset parks the slave and releases the data line
	property p_irst_idle;
		(s.irst && !s.msel) |=> (s.st == S_IDLE) ##1 !serial_data_pin_oe_out;
	endproperty
	a_irst_idle: assert property (p_irst_idle) else $error("slave not idle under interface reset");

	// Stretching drives the clock low on the next cycle
	property p_stretch;
		(s.st == S_STRETCH && s.flag && !s.msel) |=> (serial_clock_pin_oe_out && !serial_clock_pin_out);
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock not held low while flag pending");

	// Data access clears the flag unless hardware sets it at once
	property p_data_clr;
		(data_acc && !hw_set && !sfr_wr_in) |=> !s.flag;
	endproperty
	a_data_clr: assert property (p_data_clr) else $error("data access left flag set");

	// Master data pin follows data-out and enable
	property p_master_sda;
		s.msel |=> (serial_data_pin_oe_out == $past(s.master_out_enable)) && (serial_data_pin_out == $past(s.master_out_value));
	endproperty
	a_master_sda: assert property (p_master_sda) else $error("master data pin mismatch");

	// Master clock pin always driven
	property p_master_scl;
		s.msel |=> serial_clock_pin_oe_out && (serial_clock_pin_out == $past(s.master_clock_value));
	endproperty
	a_master_scl: assert property (p_master_scl) else $error("master clock pin not driven");

	// Interrupt needs flag and both enables
	property p_irq;
		##1 (irq_out == $past(s.flag && twi_int_enable_in && global_int_enable_in));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt gating wrong");

	// Second access per interrupt halts the slave
	property p_halt;
		(data_acc && s.acc && !s.msel && !s.irst && !hw_set) |=> (s.st == S_HALT);
	endproperty
	a_halt: assert property (p_halt) else $error("repeat access did not halt");

	// Not-acknowledge after transmit ends in idle with no flag
	property p_nack;
		(s.st == S_TX && scl_fall && s.bits == `TW_ACK_BIT && !s.ack_ok && !s.msel && !s.irst && !stop_ev)
			|=> (s.st == S_IDLE) && ($past(s.flag) || !s.flag || $past(sfr_wr_in));
	endproperty
	a_nack: assert property (p_nack) else $error("nack not returned to idle");

	// Stop in an active state returns to idle
	property p_stop;
		(stop_ev && s.st != S_IDLE && s.st != S_HALT && !s.msel) |=> (s.st == S_IDLE);
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not return to idle");

	// Address byte done leaves the direction bit equal to read/write
	property p_dir;
		(s.st == S_ADDR && scl_fall && s.bits == `TW_ACK_BIT && !s.msel && !s.irst && !start_ev && !stop_ev)
			|=> (s.dir == $past(s.shreg[0])) && s.flag && (s.dbuf == $past(s.shreg));
	endproperty
	a_dir: assert property (p_dir) else $error("address byte outcome wrong");

	// Scenario coverage
	c_addr_flag: cover property ((s.st == S_ADDR) ##[1:1000] (s.st == S_STRETCH));
	c_tx_byte: cover property ((s.st == S_TX) ##[1:1000] (s.st == S_STRETCH));
	c_halt: cover property (s.st == S_HALT);
	c_master_mdi: cover property (s.msel && !s.master_out_enable && scl_rise);
endmodule : tws_twowire

// >>> tws_consts.svh
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// Register addresses on the special function register port
`define TW_ADR_CTRL   8'hE8
`define TW_ADR_DATA   8'h9A
`define TW_ADR_A0     8'h9B
`define TW_ADR_A1     8'h91
`define TW_ADR_A2     8'h92
`define TW_ADR_A3     8'h93

// Reset values
`define TW_RST_A0     8'h55
`define TW_RST_AX     8'h7F
`define TW_RST_DATA   8'h00

// Control/status bit positions, master view
`define TW_B_MDO      7
`define TW_B_MDE      6
`define TW_B_MCO      5
`define TW_B_MDI      4
// Control/status bit positions, shared and slave view
`define TW_B_MSEL     3
`define TW_B_SIE      7
`define TW_B_GC       6
`define TW_B_IRST     2
`define TW_B_DIR      1
`define TW_B_FLAG     0

// Interrupt source codes
`define TW_SRC_START  2'h0
`define TW_SRC_REP    2'h1
`define TW_SRC_DATA   2'h2
`define TW_SRC_STOP   2'h3

// Core interrupt vector
`define TW_VECTOR     16'h003B

// Bit counts within a byte, and the general call address
`define TW_BYTE_BITS  4'h8
`define TW_ACK_BIT    4'h9
`define TW_LAST_BIT   4'h7
`define TW_GCALL      7'h00

// Spike filter timing
`define TW_FILT_NS    50
`define TW_CLK_NS     10
`define TW_FILT_CYC   ((`TW_FILT_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)

`endif

// >>> tws_pkg.sv
package tws_pkg;
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_RX,
		S_TX,
		S_STRETCH,
		S_HALT
	} tws_slave_e;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       s3;
		logic       lvl;
		logic [3:0] cnt;
	} tws_flt_s;

	typedef struct packed {
		tws_slave_e st;
		logic [3:0] bits;
		logic [7:0] shreg;
		logic       sda_low;
		logic       ack_ok;
		logic       matched;
		logic       rep;
		logic [7:0] adr0;
		logic [7:0] adr1;
		logic [7:0] adr2;
		logic [7:0] adr3;
		logic [7:0] dbuf;
		logic       stop_ie;
		logic       gc;
		logic [1:0] src;
		logic       msel;
		logic       irst;
		logic       dir;
		logic       flag;
		logic       acc;
		logic       master_out_value;
		logic       master_out_enable;
		logic       master_clock_value;
		logic       master_in_sample;
		logic       scl_d;
		logic       sda_d;
		logic       sda_o;
		logic       sda_oe;
		logic       scl_o;
		logic       scl_oe;
		logic       irq;
		logic [7:0] rdata;
		logic [15:0] vec;
	} tws_state_s;
endpackage : tws_pkg

// >>> tws_glitch_filter.sv
`timescale 1ns/100ps
`include "tws_consts.svh"
module tws_glitch_filter #(
	parameter int FILT_CYC = `TW_FILT_CYC
) (
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic sys_rst_in,
	// Raw pin and clean level
	input  wire logic pin_in,
	output logic      level_out
);
	import tws_pkg::*;

	tws_flt_s s;
	tws_flt_s n;

	// Three-stage sync, then demand a stable run before the level moves
	always_comb begin
		n = s;
		n.s1 = pin_in;
		n.s2 = s.s1;
		n.s3 = s.s2;
		if (s.s2 == s.s3 && s.s3 != s.lvl) begin
			if (s.cnt == 4'(FILT_CYC - 1)) begin
				n.lvl = s.s3;
				n.cnt = 4'h0;
			end else begin
				n.cnt = s.cnt + 4'h1;
			end
		end else begin
			n.cnt = 4'h0; // Short spike restarts the run
		end
	end

	// State register, bus idles high
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			s <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, cnt: 4'h0};
		end else begin
			s <= n;
		end
	end

	assign level_out = s.lvl;
endmodule : tws_glitch_filter

// >>> tws_addr_match.sv
`timescale 1ns/100ps
module tws_addr_match #(
	parameter int NUM_ADDR = 4
) (
	// Stored addresses and received address
	input  wire logic [NUM_ADDR*8-1:0] addr_tab_in,
	input  wire logic [6:0]            rx_addr_in,
	// Result
	output logic                       match_out
);
	logic [NUM_ADDR-1:0] hit;

	// One 7-bit comparator per address register
	genvar i;
	generate
		for (i = 0; i < NUM_ADDR; i++) begin : g_cmp
			assign hit[i] = (addr_tab_in[i*8 +: 7] == rx_addr_in);
		end
	endgenerate

	assign match_out = |hit;
endmodule : tws_addr_match

// >>> tws_bus_master.sv
`timescale 1ns/100ps
// Behavioural two-wire bus master; both lines are open drain with pull-ups
module tws_bus_master #(
	parameter int T_Q = 125
) (
	// Resolved bus lines
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Pull-down requests
	output logic      scl_low_out,
	output logic      sda_low_out
);
	int stall_cnt;

	// Lines released at time zero
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
		stall_cnt = 0;
	end

	// Wait (bounded) for the released clock to rise while the slave stretches it
	task scl_rise;
		for (int i = 0; i < 2000 && scl_in !== 1'b1; i++) #10;
		if (scl_in !== 1'b1) stall_cnt++;
		#T_Q;
	endtask : scl_rise

	// One bit; the clock ends low, data changes only while it is low
	task bit_xfer(input logic d, output logic s);
		sda_low_out = ~d;
		#(2 * T_Q);
		scl_low_out = 1'b0;
		scl_rise();
		s = sda_in;
		scl_low_out = 1'b1;
		#30;
	endtask : bit_xfer

	// Start or repeated start: data falls while the clock is high
	task start_cond;
		sda_low_out = 1'b0;
		#T_Q;
		scl_low_out = 1'b0;
		scl_rise();
		sda_low_out = 1'b1;
		#T_Q;
		scl_low_out = 1'b1;
		#T_Q;
	endtask : start_cond

	// Stop: data rises while the clock is high
	task stop_cond;
		sda_low_out = 1'b1;
		#T_Q;
		scl_low_out = 1'b0;
		scl_rise();
		sda_low_out = 1'b0;
		#T_Q;
	endtask : stop_cond

	// Byte out MSB first, address bytes carry read/write last; returns ack level
	task write_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
		bit_xfer(1'b1, ack);
	endtask : write_byte

	// Byte in, then our own ack or nack
	task read_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
		bit_xfer(nack, s);
	endtask : read_byte

	// Holds the clock line low from outside a transfer
	task hold_scl(input logic low);
		scl_low_out = low;
	endtask : hold_scl

	// Holds the data line low from outside a transfer
	task hold_sda(input logic low);
		sda_low_out = low;
	endtask : hold_sda
endmodule : tws_bus_master

// >>> tws_twowire_bench.sv
`timescale 1ns/100ps
module tws_twowire_bench;
	logic        clk;
	logic        rst;
	logic [7:0]  addr;
	logic        wr;
	logic        rd;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        ie_loc;
	logic        ie_glb;
	logic        irq;
	logic [15:0] vec;
	logic        sda_o;
	logic        sda_oe;
	logic        scl_o;
	logic        scl_oe;
	logic        m_scl_low;
	logic        m_sda_low;
	wire logic   sda_line;
	wire logic   scl_line;
	int          error_cnt;
	int          n_tests;
	int          cyc;
	logic        a;
	logic [7:0]  v;

	// Open-drain lines with pull-ups
	assign sda_line = ~(m_sda_low | (sda_oe & ~sda_o));
	assign scl_line = ~(m_scl_low | (scl_oe & ~scl_o));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	tws_twowire #(.FILT_CYC(5)) u_tws_twowire (
		.ref_clk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
		.sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .twi_int_enable_in(ie_loc),
		.global_int_enable_in(ie_glb), .irq_out(irq), .irq_vector_out(vec),
		.serial_data_pin_in(sda_line), .serial_data_pin_out(sda_o), .serial_data_pin_oe_out(sda_oe),
		.serial_clock_pin_in(scl_line), .serial_clock_pin_out(scl_o), .serial_clock_pin_oe_out(scl_oe));

	// Bus partner shares both lines with the slave; no other serial peripheral drives them
	tws_bus_master u_tws_bus_master (.scl_in(scl_line), .sda_in(sda_line),
		.scl_low_out(m_scl_low), .sda_low_out(m_sda_low));

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task reg_wr(input logic [7:0] ad, input logic [7:0] d);
		@(negedge clk);
		addr = ad;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : reg_wr

	task reg_chk(input string nm, input logic [7:0] ad, input logic [7:0] exp);
		@(negedge clk);
		addr = ad;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(nm, {8'h00, exp}, {8'h00, rdata});
	endtask : reg_chk

	task wait_irq;
		for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge clk);
		chk("irq", 16'h1, {15'h0, irq});
	endtask : wait_irq

	task finish_test;
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task test_reset;
		chk("vector", 16'h003B, vec);
		chk("scl_oe", 16'h0, {15'h0, scl_oe});
		reg_chk("addr0", 8'h9B, 8'h55);
		reg_chk("addr1", 8'h91, 8'h7F);
		reg_chk("addr2", 8'h92, 8'h7F);
		reg_chk("addr3", 8'h93, 8'h7F);
		reg_chk("data", 8'h9A, 8'h00);
		reg_chk("ctrl", 8'hE8, 8'h00);
		reg_wr(8'h90, 8'hA5);
		reg_chk("unmapped", 8'h90, 8'h00);
		$display("test_reset done");
	endtask : test_reset

	task test_master;
		reg_wr(8'hE8, 8'hC8);
		repeat (2) @(negedge clk);
		chk("sda drive", 16'h3, {14'h0, sda_oe, sda_o});
		chk("scl drive", 16'h2, {14'h0, scl_oe, scl_o});
		reg_wr(8'hE8, 8'h68);
		repeat (2) @(negedge clk);
		chk("sda low", 16'h2, {14'h0, sda_oe, sda_o});
		chk("scl high", 16'h3, {14'h0, scl_oe, scl_o});
		reg_wr(8'hE8, 8'h08);
		u_tws_bus_master.hold_sda(1'b1);
		repeat (12) @(negedge clk);
		chk("sda off", 16'h0, {15'h0, sda_oe});
		reg_wr(8'hE8, 8'h28);
		repeat (12) @(negedge clk);
		reg_chk("sample low", 8'hE8, 8'h28);
		reg_wr(8'hE8, 8'h08);
		u_tws_bus_master.hold_sda(1'b0);
		repeat (12) @(negedge clk);
		reg_chk("no rise", 8'hE8, 8'h08);
		reg_wr(8'hE8, 8'h28);
		repeat (12) @(negedge clk);
		reg_chk("sample high", 8'hE8, 8'h38);
		u_tws_bus_master.hold_sda(1'b1);
		u_tws_bus_master.hold_scl(1'b1);
		#30;
		u_tws_bus_master.hold_scl(1'b0);
		repeat (12) @(negedge clk);
		reg_chk("spike", 8'hE8, 8'h38);
		u_tws_bus_master.hold_sda(1'b0);
		reg_wr(8'hE8, 8'h00);
		repeat (12) @(negedge clk);
		chk("slave scl", 16'h0, {15'h0, scl_oe});
		$display("test_master done");
	endtask : test_master

	task test_rx_tx;
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'hAA, a);
		chk("ack addr", 16'h0, {15'h0, a});
		wait_irq();
		u_tws_bus_master.hold_scl(1'b0);
		repeat (20) @(negedge clk);
		chk("stretch", 16'h0, {15'h0, scl_line});
		u_tws_bus_master.hold_scl(1'b1);
		reg_chk("ctrl start", 8'hE8, 8'h01);
		ie_glb = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq masked", 16'h0, {15'h0, irq});
		ie_glb = 1'b1;
		ie_loc = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq local masked", 16'h0, {15'h0, irq});
		ie_loc = 1'b1;
		reg_chk("data addr", 8'h9A, 8'hAA);
		@(negedge clk);
		chk("irq clear", 16'h0, {15'h0, irq});
		u_tws_bus_master.write_byte(8'h3C, a);
		chk("ack data", 16'h0, {15'h0, a});
		wait_irq();
		reg_chk("ctrl data", 8'hE8, 8'h21);
		reg_chk("rx data", 8'h9A, 8'h3C);
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'hAB, a);
		chk("ack rd", 16'h0, {15'h0, a});
		wait_irq();
		reg_chk("ctrl rep", 8'hE8, 8'h13);
		reg_wr(8'h9A, 8'h96);
		u_tws_bus_master.read_byte(1'b1, v);
		chk("tx data", {8'h00, 8'h96}, {8'h00, v});
		repeat (40) @(negedge clk);
		chk("nack no irq", 16'h0, {15'h0, irq});
		u_tws_bus_master.stop_cond();
		$display("test_rx_tx done");
	endtask : test_rx_tx

	task test_match;
		reg_wr(8'h92, 8'h21);
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'h42, a);
		chk("ack third", 16'h0, {15'h0, a});
		wait_irq();
		reg_chk("data third", 8'h9A, 8'h42);
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'h00, a);
		chk("ack gcall", 16'h0, {15'h0, a});
		wait_irq();
		reg_chk("gc set", 8'hE8, 8'h51);
		reg_chk("data gcall", 8'h9A, 8'h00);
		reg_wr(8'hE8, 8'h00);
		reg_chk("gc clear", 8'hE8, 8'h10);
		u_tws_bus_master.stop_cond();
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'h24, a);
		chk("nack miss", 16'h1, {15'h0, a});
		u_tws_bus_master.stop_cond();
		$display("test_match done");
	endtask : test_match

	task test_halt;
		reg_wr(8'hE8, 8'h80);
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'hAA, a);
		wait_irq();
		reg_chk("data", 8'h9A, 8'hAA);
		u_tws_bus_master.stop_cond();
		wait_irq();
		reg_chk("ctrl stop", 8'hE8, 8'hB1);
		reg_chk("data once", 8'h9A, 8'hAA);
		reg_wr(8'h9A, 8'h00);
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'hAA, a);
		chk("halted nack", 16'h1, {15'h0, a});
		u_tws_bus_master.stop_cond();
		reg_wr(8'hE8, 8'h04);
		reg_wr(8'hE8, 8'h00);
		repeat (12) @(negedge clk);
		u_tws_bus_master.start_cond();
		u_tws_bus_master.write_byte(8'hAA, a);
		chk("ack after reset", 16'h0, {15'h0, a});
		wait_irq();
		reg_chk("data again", 8'h9A, 8'hAA);
		u_tws_bus_master.stop_cond();
		repeat (40) @(negedge clk);
		chk("no stop irq", 16'h0, {15'h0, irq});
		chk("no stall", 16'h0, 16'(u_tws_bus_master.stall_cnt));
		$display("test_halt done");
	endtask : test_halt

	// Cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		rst = 1'b1;
		addr = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
		ie_loc = 1'b1;
		ie_glb = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (12) @(negedge clk);
		test_reset();
		test_master();
		test_rx_tx();
		test_match();
		test_halt();
		finish_test();
	end
endmodule : tws_twowire_bench
